// *** design/acksr_params.svh ***
// Constants for the acknowledge / status responder.
// Included by the package and the design modules; definitions only.
`ifndef ACKSR_PARAMS_SVH
`define ACKSR_PARAMS_SVH

`define ACKSR_CODE_ACK      8'h10
`define ACKSR_CODE_VER      8'h11
`define ACKSR_SUB_SET       8'h01
`define ACKSR_SUB_QUERY     8'h02
`define ACKSR_SUB_SYS       8'h03
`define ACKSR_SUB_AUTO      8'h04
`define ACKSR_SUB_ALL       8'hFF
`define ACKSR_VER_NAV       8'h01
`define ACKSR_VER_BOOT      8'h02
`define ACKSR_VER_DSP       8'h03
`define ACKSR_ST_OK         4'h0
`define ACKSR_ST_PREPARSE   4'h1
`define ACKSR_ST_CHECKSUM   4'h2
`define ACKSR_ST_UNKNOWN    4'h3
`define ACKSR_ST_LENGTH     4'h4
`define ACKSR_ST_VALUE      4'h5
`define ACKSR_ST_CONTRA     4'h6
`define ACKSR_ST_FULL       4'h7
`define ACKSR_ST_NODATA     4'h8
`define ACKSR_ST_EXECFAIL   4'h9
`define ACKSR_MAX_STREAM    8'h80
`define ACKSR_LEN_NONIDX    3'h3
`define ACKSR_LEN_IDX       3'h4
`define ACKSR_LEN_SYS       3'h2
`define ACKSR_LEN_VER       3'h7
`define ACKSR_CODE_MASK     8'h7F
`define ACKSR_BUF_DEPTH     2
`define ACKSR_YEAR_BASE     16'h07D0

`endif

// *** design/acksr_pkg.sv ***
// Types shared by the responder and its output buffer.
// Assumes acksr_params.svh is on the include path.
`include "acksr_params.svh"

package acksr_pkg;

    // Command origin as seen by the parser
    typedef enum logic [1:0] {
        ACKSR_ORG_SET,
        ACKSR_ORG_QUERY,
        ACKSR_ORG_AUTO,
        ACKSR_ORG_SYS
    } acksr_origin_t;

    // Emission state of the responder
    typedef enum logic [2:0] {
        ACKSR_IDLE,
        ACKSR_HDR_CODE,
        ACKSR_HDR_SUB,
        ACKSR_PAYLOAD,
        ACKSR_WAIT_SWITCH
    } acksr_state_t;

    // Output byte with its end-of-message marker
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } acksr_byte_t;

endpackage

// *** design/acksr_skid_buf.sv ***
// Two-entry buffer for message bytes on their way to the serial framer.
// Assumes one clock, synchronous active-high reset, and a clock enable.
`timescale 1ns/1ps
`default_nettype none
`include "acksr_params.svh"

module acksr_skid_buf
    import acksr_pkg::*;
(
    input  wire logic        ref_clk,   // Core clock
    input  wire logic        reset,     // Synchronous reset
    input  wire logic        clk_en,    // Freezes state when low
    input  wire acksr_byte_t in_byte,   // Incoming byte
    input  wire logic        in_valid,  // Incoming byte present
    output logic             in_ready,  // Room for a byte
    output acksr_byte_t      out_byte,  // Oldest byte held
    output logic             out_valid, // Buffer not empty
    input  wire logic        out_ready  // Receiver accepts byte
);

    // Whole state in one struct
    typedef struct packed {
        acksr_byte_t [`ACKSR_BUF_DEPTH-1:0] mem;  // Storage, entry 0 oldest
        logic [1:0]                         cnt;  // Fill level 0..2
    } acksr_buf_state_t;

    acksr_buf_state_t st_r;   // Registered state
    acksr_buf_state_t st_nxt; // Next state

    // Shift-style buffer; depth two keeps it cheap and honest
    always_comb begin
        logic push;
        logic pop;
        st_nxt = st_r;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        if (pop) begin // Shift oldest out
            st_nxt.mem[0] = st_r.mem[1];
            st_nxt.cnt    = st_r.cnt - 2'h1;
        end
        if (push) begin // Write behind the newest
            st_nxt.mem[st_nxt.cnt[0]] = in_byte;
            st_nxt.cnt                = st_nxt.cnt + 2'h1;
        end
    end

    // Register update under clock enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_byte  = st_r.mem[0];

endmodule // acksr_skid_buf

`default_nettype wire

// *** design/acksr_responder.sv ***
// Acknowledge / error response and version report builder.
// Assumes the parser hands over one outcome per complete command frame.
`timescale 1ns/1ps
`default_nettype none
`include "acksr_params.svh"

module acksr_responder
    import acksr_pkg::*;
(
    input  wire logic          ref_clk,        // 25 MHz core clock
    input  wire logic          reset,          // Synchronous active-high reset
    input  wire logic          clk_en,         // Freezes all state when low

    // Parser outcome, one pulse per completed frame
    input  wire logic          cmd_done,       // Frame fully processed
    output logic               cmd_ready,      // Responder can take an outcome
    input  wire acksr_origin_t cmd_origin,     // Set, query, auto or system
    input  wire logic [7:0]    cmd_code,       // Command or system code
    input  wire logic [7:0]    cmd_subcode,    // Command subcode, FF for all
    input  wire logic          cmd_indexed,    // Report is indexed
    input  wire logic [7:0]    cmd_index,      // Channel or satellite index
    input  wire logic          cmd_all,        // Query-all request
    input  wire logic          cmd_multi,      // Produced several responses
    input  wire logic          cmd_proto_chg,  // Command changes port protocol
    input  wire logic          cmd_override,   // Host override of conflicts

    // Parser stage fault flags
    input  wire logic [7:0]    stream_len,     // Assembled stream length
    input  wire logic          ctrl_char_err,  // Control character fault
    input  wire logic          checksum_err,   // Checksum mismatch
    input  wire logic          unknown_err,    // Unknown code or subcode
    input  wire logic          length_err,     // Wrong message length
    input  wire logic          value_err,      // Unreasonable value
    input  wire logic          contra_err,     // Conflicts with GPS data
    input  wire logic          table_full,     // Data table full
    input  wire logic          no_data,        // Data not available
    input  wire logic          exec_fail,      // System command failed

    // Version report request
    input  wire logic          ver_req,        // Query for version report
    input  wire logic [7:0]    ver_sub,        // Firmware block subcode
    input  wire logic [7:0]    ver_major,      // Major number
    input  wire logic [7:0]    ver_minor,      // Minor number
    input  wire logic [7:0]    ver_release,    // 0 release, else beta
    input  wire logic [7:0]    ver_day,        // Release day
    input  wire logic [7:0]    ver_month,      // Release month
    input  wire logic [15:0]   ver_year,       // Release year

    // Message byte stream to framer
    output logic [7:0]         msg_data,       // Message byte
    output logic               msg_last,       // Last byte of message
    output logic               msg_valid,      // Byte present
    input  wire logic          msg_ready,      // Framer takes byte

    // Protocol switch handshake
    output logic               proto_switch,   // Pulse: apply new protocol now
    output logic [3:0]         last_status     // Status of last outcome
);

    // Life of one acknowledge with a prompt framer:
    //   edge 0  outcome taken, cmd_ready drops
    //   edge 1  code byte enters the buffer
    //   edge 2  code byte taken, subcode enters
    //   then one payload byte a cycle, status last
    // A framer stall backs up into the emitter and
    // holds cmd_ready low; no byte is ever dropped.
    // Outcomes offered while busy are not queued,
    // so the parser must wait for cmd_ready.

    // Whole state in one struct
    typedef struct packed {
        acksr_state_t     state;      // Emission state
        logic [7:0]       code;       // Message code byte
        logic [7:0]       sub;        // Message subcode byte

        logic [7:0][7:0]  pay;        // Payload bytes
        logic [2:0]       len;        // Payload length
        logic [2:0]       pos;        // Payload byte position

        logic             sw_pend;    // Protocol switch after send
        logic             sw_pulse;   // Switch pulse output
        logic [3:0]       status;     // Last status
    } acksr_rsp_state_t;

    acksr_rsp_state_t st_r;    // Registered state
    acksr_rsp_state_t st_nxt;  // Next state

    acksr_byte_t      push_byte;  // Byte to buffer
    logic             push_valid; // Byte offered to buffer
    logic             push_ready; // Buffer has room
    acksr_byte_t      out_byte;   // Buffered byte

    logic [3:0]       status_c;   // Status decode of current outcome
    logic             need_ack;   // Outcome calls for an ack
    logic [7:0]       sub_c;      // Subcode field, FF for query-all

    // Parser status: first failing stage wins, in stream order
    always_comb begin
        status_c = `ACKSR_ST_OK;

        if (ctrl_char_err || (stream_len > `ACKSR_MAX_STREAM)) begin
            status_c = `ACKSR_ST_PREPARSE;
        end else if (checksum_err) begin
            status_c = `ACKSR_ST_CHECKSUM;
        end else if (unknown_err) begin
            status_c = `ACKSR_ST_UNKNOWN;
        end else if (length_err) begin
            status_c = `ACKSR_ST_LENGTH;
        end else if (cmd_origin == ACKSR_ORG_SYS) begin
            if (exec_fail) begin
                status_c = `ACKSR_ST_EXECFAIL;
            end
        end else if (value_err) begin
            status_c = `ACKSR_ST_VALUE;
        end else if (contra_err && !cmd_override) begin
            status_c = `ACKSR_ST_CONTRA;
        end else if (table_full) begin
            status_c = `ACKSR_ST_FULL;
        end else if (no_data) begin
            status_c = `ACKSR_ST_NODATA;
        end
    end

    // Ack needed: sets and system always, queries and autos only if failed, multi or query-all
    always_comb begin
        case (cmd_origin)
            ACKSR_ORG_SET:   need_ack = 1'b1;
            ACKSR_ORG_SYS:   need_ack = 1'b1;
            ACKSR_ORG_QUERY,
            ACKSR_ORG_AUTO:  need_ack = (status_c != `ACKSR_ST_OK) || cmd_multi || cmd_all;
            default:         need_ack = 1'b1;
        endcase
    end

    // Query-all collapses to one ack carrying FF
    assign sub_c = cmd_all ? `ACKSR_SUB_ALL : cmd_subcode;

    // Outcome capture and byte emission
    always_comb begin
        st_nxt          = st_r;
        st_nxt.sw_pulse = 1'b0;
        push_valid      = 1'b0;
        push_byte       = '0;

        case (st_r.state)
            ACKSR_IDLE: begin
                // A completed frame outcome is captured and acked if need_ack, ahead of any version request
                if (cmd_done) begin
                    st_nxt.status  = status_c;
                    st_nxt.code    = `ACKSR_CODE_ACK;
                    st_nxt.pay     = '0;
                    st_nxt.pos     = 3'h0;

                    // Switch only if the command was accepted
                    st_nxt.sw_pend = cmd_proto_chg && (status_c == `ACKSR_ST_OK);

                    // System form: code then status, no subcode byte
                    if (cmd_origin == ACKSR_ORG_SYS) begin
                        st_nxt.sub    = `ACKSR_SUB_SYS;
                        st_nxt.pay[0] = cmd_code;
                        st_nxt.pay[1] = {4'h0, status_c};
                        st_nxt.len    = `ACKSR_LEN_SYS;
                    end else begin
                        case (cmd_origin)
                            ACKSR_ORG_SET:   st_nxt.sub = `ACKSR_SUB_SET;
                            ACKSR_ORG_QUERY: st_nxt.sub = `ACKSR_SUB_QUERY;
                            default:         st_nxt.sub = `ACKSR_SUB_AUTO;
                        endcase
                        st_nxt.pay[0] = cmd_code & `ACKSR_CODE_MASK;
                        st_nxt.pay[1] = sub_c;
                        if (cmd_indexed) begin
                            st_nxt.pay[2] = cmd_all ? `ACKSR_SUB_ALL : (cmd_index & `ACKSR_CODE_MASK);
                            st_nxt.pay[3] = {4'h0, status_c};
                            st_nxt.len    = `ACKSR_LEN_IDX;
                        end else begin
                            st_nxt.pay[2] = {4'h0, status_c};
                            st_nxt.len    = `ACKSR_LEN_NONIDX;
                        end
                    end

                    // A successful single query ends here
                    if (need_ack) begin
                        st_nxt.state = ACKSR_HDR_CODE;
                    end else if (st_nxt.sw_pend) begin
                        st_nxt.state = ACKSR_WAIT_SWITCH;
                    end
                end else if (ver_req) begin
                    // Version report, unknown subcode answered with status 3
                    if (ver_sub >= `ACKSR_VER_NAV && ver_sub <= `ACKSR_VER_DSP) begin
                        st_nxt.code   = `ACKSR_CODE_VER;
                        st_nxt.sub    = ver_sub;

                        st_nxt.pay[0] = ver_major;
                        st_nxt.pay[1] = ver_minor;
                        st_nxt.pay[2] = ver_release;
                        st_nxt.pay[3] = ver_day;
                        st_nxt.pay[4] = ver_month;
                        st_nxt.pay[5] = ver_year[15:8];
                        st_nxt.pay[6] = ver_year[7:0];
                        st_nxt.pay[7] = 8'h00;

                        st_nxt.len    = `ACKSR_LEN_VER;
                        st_nxt.status = `ACKSR_ST_OK;
                    end else begin
                        st_nxt.code   = `ACKSR_CODE_ACK;
                        st_nxt.sub    = `ACKSR_SUB_QUERY;

                        st_nxt.pay    = '0;
                        st_nxt.pay[0] = `ACKSR_CODE_VER;
                        st_nxt.pay[1] = ver_sub;
                        st_nxt.pay[2] = {4'h0, `ACKSR_ST_UNKNOWN};
                        st_nxt.len    = `ACKSR_LEN_NONIDX;
                        st_nxt.status = `ACKSR_ST_UNKNOWN;
                    end

                    st_nxt.pos     = 3'h0;
                    st_nxt.sw_pend = 1'b0;
                    st_nxt.state   = ACKSR_HDR_CODE;
                end
            end

            ACKSR_HDR_CODE: begin
                // Message code byte
                push_valid = 1'b1;
                push_byte  = '{data: st_r.code, last: 1'b0};

                if (push_ready) begin
                    st_nxt.state = ACKSR_HDR_SUB;
                end
            end

            ACKSR_HDR_SUB: begin
                // Message subcode byte
                push_valid = 1'b1;
                push_byte  = '{data: st_r.sub, last: 1'b0};

                if (push_ready) begin
                    st_nxt.state = ACKSR_PAYLOAD;
                end
            end

            ACKSR_PAYLOAD: begin
                // Payload in order; in an acknowledge the status is the last one
                push_valid = 1'b1;
                push_byte  = '{data: st_r.pay[st_r.pos], last: (st_r.pos == st_r.len - 3'h1)};

                if (push_ready) begin
                    st_nxt.pos = st_r.pos + 3'h1;
                    if (st_r.pos == st_r.len - 3'h1) begin
                        st_nxt.state = st_r.sw_pend ? ACKSR_WAIT_SWITCH : ACKSR_IDLE;
                    end
                end
            end

            ACKSR_WAIT_SWITCH: begin
                // Hold the switch until the buffer has drained in the old protocol
                if (!msg_valid) begin
                    st_nxt.sw_pulse = 1'b1;
                    st_nxt.sw_pend  = 1'b0;
                    st_nxt.state    = ACKSR_IDLE;
                end
            end

            default: begin
                st_nxt.state = ACKSR_IDLE;
            end
        endcase
    end

    // State register under clock enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r       <= '0;
            st_r.state <= ACKSR_IDLE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Output buffer; a framer stall backs up into the emitter
    acksr_skid_buf u_buf (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_byte   (push_byte),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_byte  (out_byte),
        .out_valid (msg_valid),
        .out_ready (msg_ready)
    );

    assign msg_data     = out_byte.data;
    assign msg_last     = out_byte.last;

    assign cmd_ready    = (st_r.state == ACKSR_IDLE);
    assign proto_switch = st_r.sw_pulse;
    assign last_status  = st_r.status;

endmodule // acksr_responder

`default_nettype wire

// *** testbench/acksr_responder_properties.sv ***
// Port-level checks of the acknowledge / status responder.
// Assumes clk_en is held high by the bench and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module acksr_resp_props
    import acksr_pkg::*;
(
    input wire logic          ref_clk,      // Core clock
    input wire logic          reset,        // Sync reset
    input wire logic          cmd_done,     // Outcome strobe
    input wire logic          cmd_ready,    // Outcome accepted
    input wire acksr_origin_t cmd_origin,   // Command origin
    input wire logic [7:0]    msg_data,     // Output byte
    input wire logic          msg_last,     // Final byte
    input wire logic          msg_valid,    // Byte present
    input wire logic          msg_ready,    // Sink takes byte
    input wire logic          proto_switch, // Switch pulse
    input wire logic [3:0]    last_status   // Last status
);
    logic       first_r; // Next accepted byte opens a message
    logic       ack_r;   // Message under way is an acknowledge
    logic [3:0] cnt_r;   // Bytes accepted so far in message
    wire logic  take;    // Byte handed over this cycle

    assign take = msg_valid && msg_ready;

    // Track message boundaries from accepted bytes only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            first_r <= 1'b1;
            ack_r   <= 1'b0;
            cnt_r   <= 4'h0;
        end else if (take) begin
            first_r <= msg_last;
            cnt_r   <= msg_last ? 4'h0 : cnt_r + 4'h1;
            if (first_r) begin
                ack_r <= (msg_data == 8'h10);
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Steps of an acknowledge: capture of a set, then the code byte
    sequence s_set_taken;
        cmd_done && cmd_ready && cmd_origin == ACKSR_ORG_SET;
    endsequence
    sequence s_ack_code;
        take && first_r && msg_data == 8'h10;
    endsequence

    AST_RESET_STATE: assert property ($fell(reset) |-> !msg_valid && cmd_ready && !proto_switch && last_status == 4'h0)
        else $error("outputs not idle after reset");
    AST_SET_BUSY: assert property (s_set_taken |=> !cmd_ready)
        else $error("ready stayed high after capture");
    AST_SET_ACKED: assert property (s_set_taken |-> ##[2:8] (msg_valid && first_r && msg_data == 8'h10))
        else $error("set not acknowledged");
    AST_ROSE_AFTER_BUSY: assert property ($rose(msg_valid) |-> !$past(cmd_ready))
        else $error("byte appeared without a capture");
    AST_HOLD_STALL: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_last))
        else $error("stalled byte changed or lost");
    AST_ACK_SUBCODE: assert property (s_ack_code |=> msg_valid && (msg_data inside {8'h01, 8'h02, 8'h03, 8'h04}))
        else $error("bad acknowledge subcode");
    AST_STATUS_RANGE: assert property (take && msg_last && ack_r |-> msg_data <= 8'h09)
        else $error("status byte out of range");
    AST_ACK_LEN: assert property (take && msg_last && ack_r |-> cnt_r inside {4'h3, 4'h4, 4'h5})
        else $error("acknowledge length wrong");
    AST_VER_LEN: assert property (take && msg_last && !ack_r && !first_r |-> cnt_r == 4'h8)
        else $error("version report length wrong");
    AST_PROTO_PULSE: assert property (proto_switch |-> !msg_valid ##1 !proto_switch)
        else $error("switch pulse early or long");
endmodule // acksr_resp_props

bind acksr_responder acksr_resp_props chk_u (.ref_clk, .reset, .cmd_done, .cmd_ready, .cmd_origin,
    .msg_data, .msg_last, .msg_valid, .msg_ready, .proto_switch, .last_status);

`default_nettype wire

// *** testbench/acksr_host_sink.sv ***
// Receiving side of the message byte stream, with selectable pacing.
// Assumes bytes are offered with valid/ready on the core clock.
`timescale 1ns/1ps
`default_nettype none

module acksr_host_sink (
    input  wire logic       ref_clk,   // Core clock
    input  wire logic       reset,     // Sync reset
    input  wire logic [1:0] stall,     // 0 prompt, 1 alternate, 2 held off
    input  wire logic [7:0] msg_data,  // Offered byte
    input  wire logic       msg_last,  // Final byte flag
    input  wire logic       msg_valid, // Byte present
    output logic            msg_ready  // Byte taken
);
    logic [8:0] got[$]; // Accepted bytes, last flag on top
    logic       tog;    // Alternating acceptance phase

    initial begin
        msg_ready = 1'b0;
        tog = 1'b0;
    end

    // Take bytes at the edge, repace ready just after it
    always @(posedge ref_clk) begin
        if (!reset && msg_valid && msg_ready)
            got.push_back({msg_last, msg_data});
        tog = !tog;
        #1 msg_ready = !reset && (stall == 2'd0 || (stall == 2'd1 && tog));
    end
endmodule // acksr_host_sink

`default_nettype wire

// *** testbench/ack_status_responder_tb.sv ***
// Self-checking bench for the responder; one task per scenario.
// Assumes the sink model in acksr_host_sink.sv and clk_en tied high.
`timescale 1ns/1ps
`default_nettype none

module ack_status_responder_tb;
    import acksr_pkg::*;
    logic          ref_clk, reset;         // Clock and sync reset
    logic          cmd_done, ver_req;      // Request strobes
    acksr_origin_t cmd_origin;             // Command origin
    logic [7:0]    cmd_code, cmd_subcode, cmd_index, stream_len, ver_sub; // Outcome bytes
    logic          cmd_indexed, cmd_all, cmd_multi, cmd_proto_chg, cmd_override; // Flags
    logic [8:0]    err_v;                  // Stage faults, ctrl error on top
    logic [55:0]   ver_v;                  // Version fields
    logic [1:0]    stall;                  // Sink pacing
    logic          cmd_ready, msg_last, msg_valid, msg_ready, proto_switch; // Outputs
    logic [7:0]    msg_data;               // Output byte
    logic [3:0]    last_status;            // Last status
    int            error_cnt, samples_checked, sw_cnt; // Tallies

    acksr_responder dut_u (.ref_clk, .reset, .clk_en(1'b1), .cmd_done, .cmd_ready, .cmd_origin,
        .cmd_code, .cmd_subcode, .cmd_indexed, .cmd_index, .cmd_all, .cmd_multi, .cmd_proto_chg,
        .cmd_override, .stream_len, .ctrl_char_err(err_v[8]), .checksum_err(err_v[7]),
        .unknown_err(err_v[6]), .length_err(err_v[5]), .value_err(err_v[4]), .contra_err(err_v[3]),
        .table_full(err_v[2]), .no_data(err_v[1]), .exec_fail(err_v[0]), .ver_req, .ver_sub,
        .ver_major(ver_v[55:48]), .ver_minor(ver_v[47:40]), .ver_release(ver_v[39:32]),
        .ver_day(ver_v[31:24]), .ver_month(ver_v[23:16]), .ver_year(ver_v[15:0]),
        .msg_data, .msg_last, .msg_valid, .msg_ready, .proto_switch, .last_status);
    acksr_host_sink snk_u (.ref_clk, .reset, .stall, .msg_data, .msg_last, .msg_valid, .msg_ready);

    // Free-running 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Count switch pulses as they happen
    always @(posedge ref_clk) if (proto_switch === 1'b1) sw_cnt++;

    task automatic complete_run();
        $display("Checks %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One cycle, with a bound on how long any wait may run
    task automatic step(inout int n);
        @(posedge ref_clk);
        #1;
        n++;
        if (n > 300) begin
            error_cnt++;
            $display("Error at %0t: wait expired", $time);
            complete_run();
        end
    endtask

    task automatic clr();
        {cmd_done, ver_req, cmd_indexed, cmd_all, cmd_multi, cmd_proto_chg, cmd_override} = '0;
        {cmd_code, cmd_subcode, cmd_index, ver_sub, err_v, ver_v} = '0;
        cmd_origin = ACKSR_ORG_SET;
        stream_len = 8'h10;
    endtask

    // Wait for ready, then strobe one outcome or version request
    task automatic fire(input bit ver);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1) step(n);
        if (ver) ver_req = 1'b1;
        else cmd_done = 1'b1;
        step(n);
        clr();
    endtask

    // Whole message compared byte by byte, then no stray bytes
    task automatic expect_msg(input logic [7:0] exp[$]);
        int n;
        n = 0;
        while (snk_u.got.size() < exp.size()) step(n);
        repeat (4) step(n);
        chk(16'(snk_u.got.size()), 16'(exp.size()));
        foreach (exp[i]) chk(16'(snk_u.got[i]), {7'h0, i == exp.size() - 1, exp[i]});
        snk_u.got.delete();
    endtask

    task automatic ack(input acksr_origin_t o, input logic [7:0] c, input logic [7:0] s,
                       input logic [7:0] exp[$]);
        cmd_origin = o;
        cmd_code = c;
        cmd_subcode = s;
        fire(1'b0);
        expect_msg(exp);
    endtask

    // Set with given faults, status byte checked
    task automatic set_case(input logic [8:0] e, input logic [7:0] len, input logic ov, input logic [7:0] st);
        err_v = e;
        stream_len = len;
        cmd_override = ov;
        ack(ACKSR_ORG_SET, 8'h21, 8'h01, '{8'h10, 8'h01, 8'h21, 8'h01, st});
        chk(16'(last_status), 16'(st));
    endtask

    task automatic t_status();
        for (int s = 1; s <= 8; s++) set_case(9'h1 << (9 - s), 8'h10, 1'b0, 8'(s));
        set_case(9'h000, 8'h81, 1'b0, 8'h01);
        set_case(9'h000, 8'h80, 1'b0, 8'h00);
        set_case(9'h180, 8'h10, 1'b0, 8'h01);
        set_case(9'h008, 8'h10, 1'b1, 8'h00);
    endtask

    task automatic t_query();
        int n;
        n = 0;
        cmd_origin = ACKSR_ORG_QUERY;
        fire(1'b0);
        repeat (20) step(n);
        chk(16'(snk_u.got.size()), 16'h0);
        cmd_indexed = 1'b1;
        cmd_index = 8'h05;
        err_v = 9'h002;
        ack(ACKSR_ORG_QUERY, 8'h33, 8'h01, '{8'h10, 8'h02, 8'h33, 8'h01, 8'h05, 8'h08});
        cmd_all = 1'b1;
        cmd_multi = 1'b1;
        ack(ACKSR_ORG_QUERY, 8'h26, 8'h01, '{8'h10, 8'h02, 8'h26, 8'hFF, 8'h00});
        cmd_multi = 1'b1;
        ack(ACKSR_ORG_AUTO, 8'h22, 8'h01, '{8'h10, 8'h04, 8'h22, 8'h01, 8'h00});
    endtask

    task automatic t_sys();
        ack(ACKSR_ORG_SYS, 8'h05, 8'h00, '{8'h10, 8'h03, 8'h05, 8'h00});
        err_v = 9'h001;
        ack(ACKSR_ORG_SYS, 8'h05, 8'h00, '{8'h10, 8'h03, 8'h05, 8'h09});
    endtask

    // Sink held off: buffer fills, switch waits until the ack is out
    task automatic t_proto();
        int n;
        n = 0;
        stall = 2'd2;
        sw_cnt = 0;
        cmd_proto_chg = 1'b1;
        cmd_code = 8'h22;
        cmd_subcode = 8'h02;
        fire(1'b0);
        repeat (12) step(n);
        chk(16'(cmd_ready), 16'h0);
        chk(16'(sw_cnt), 16'h0);
        stall = 2'd0;
        expect_msg('{8'h10, 8'h01, 8'h22, 8'h02, 8'h00});
        chk(16'(sw_cnt), 16'h1);
    endtask

    task automatic t_version();
        for (int s = 1; s <= 3; s++) begin
            ver_sub = 8'(s);
            ver_v = {8'h02, 8'h1E, 8'h00, 8'h0F, 8'h03, 16'h07D7};
            fire(1'b1);
            expect_msg('{8'h11, 8'(s), 8'h02, 8'h1E, 8'h00, 8'h0F, 8'h03, 8'h07, 8'hD7});
        end
        ver_sub = 8'h04;
        fire(1'b1);
        expect_msg('{8'h10, 8'h02, 8'h11, 8'h04, 8'h03});
    endtask

    // Main sequence: reset, then scenarios with the sink pacing varied
    initial begin
        {error_cnt, samples_checked, sw_cnt} = '0;
        reset = 1'b1;
        stall = 2'd0;
        clr();
        repeat (16) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_status();
        stall = 2'd1;
        t_query();
        t_sys();
        t_proto();
        t_version();
        complete_run();
    end
endmodule // ack_status_responder_tb

`default_nettype wire
